/* hw/mmc_pkg.sv */
// Constants shared by the memory map and mode control block.
// Assumes an 18-bit global address space and an 8-bit register index.
package mmc_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_RSVD_A = 8'h0A; // Reserved, reads zero
	localparam logic [7:0] IDX_MODE = 8'h0B; // Operating mode select
	localparam logic [7:0] IDX_RSVD_10 = 8'h10; // Reserved, reads zero
	localparam logic [7:0] IDX_DIRECT = 8'h11; // Direct page base
	localparam logic [7:0] IDX_RSVD_12 = 8'h12; // Reserved, reads zero
	localparam logic [7:0] IDX_RSVD_13 = 8'h13; // Reserved, reads zero
	localparam logic [7:0] IDX_RSVD_14 = 8'h14; // Reserved, reads zero
	localparam logic [7:0] IDX_PROGRAM_PAGE_WINDOW_INDEX = 8'h15; // Program page window index
	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int MODE_BIT = 7; // Mode bit position in its register
	localparam logic MODE_NORMAL = 1'b1; // Normal single chip
	localparam logic MODE_SPECIAL = 1'b0; // Special single chip
	localparam logic [7:0] DIRECT_RST = 8'h00; // Direct page after reset
	localparam int PAGE_W = 4; // Page index width
	localparam logic [3:0] PROGRAM_PAGE_WINDOW_INDEX_RST = 4'hE; // Window page after reset
	////////////////////////////////////////////////////////////////////////////
	// Local map
	localparam logic [3:0] PAGE_LOW = 4'hC; // Fixed page at 0x0000
	localparam logic [3:0] PAGE_MID = 4'hD; // Fixed page at 0x4000
	localparam logic [3:0] PAGE_TOP = 4'hF; // Fixed page at 0xC000
	localparam logic [1:0] WIN_SLOT = 2'b10; // Local 0x8000-0xBFFF window
	localparam logic [1:0] LOW_SLOT = 2'b00; // Local 0x0000-0x3FFF
	localparam logic [1:0] MID_SLOT = 2'b01; // Local 0x4000-0x7FFF
	////////////////////////////////////////////////////////////////////////////
	// Global map
	localparam logic [17:0] REG_TOP = 18'h003FF; // Register space top
	localparam logic [17:0] RAM_END = 18'h04000; // RAM ends below this
	localparam logic [17:0] DFL_LO = 18'h04400; // Data flash bottom
	localparam logic [17:0] DFL_HI = 18'h053FF; // Data flash top
	localparam logic [18:0] PFL_END = 19'h40000; // Program flash ends below this
	////////////////////////////////////////////////////////////////////////////
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10; // Only transfer type used
	localparam logic HRESP_OKAY = 1'b0; // Always answered
	// Last bus owner on the on-chip side
	typedef enum logic [1:0] {
		OWN_NONE = 2'b00,
		OWN_CPU = 2'b01,
		OWN_BDM = 2'b10
	} owner_t;
endpackage : mmc_pkg

/* hw/page_map.sv */
// Local to global address expansion with implemented-range check.
// Assumes page and direct bases come from registers on the same clock.
`timescale 1ns/100ps
module page_map #(
	parameter logic [17:0] RAM_SIZE = 18'h01800, // Implemented RAM bytes
	parameter logic [18:0] FLASH_SIZE = 19'h10000 // Implemented program flash bytes
) (
	input wire logic [15:0] local_addr, // Local address from a master
	input wire logic direct_mode, // Access uses direct addressing
	input wire logic [7:0] direct_base, // Direct page base
	input wire logic [3:0] page_index, // Program window page
	output logic [17:0] global_addr, // Expanded global address
	output logic is_pflash, // Hits program flash
	output logic is_unimpl // Hits nothing on chip
);
	logic [15:0] eff_addr; // Local address after direct substitution
	logic [3:0] page; // Selected 16 kB page
	logic [18:0] ga_ext; // Global address widened for range compares

	////////////////////////////////////////////////////////////////////////////
	// Direct page supplies the upper byte; 256-byte page both maps
	always_comb begin
		eff_addr = direct_mode ? {direct_base, local_addr[7:0]} : local_addr;
	end

	// Page selection: window uses the index, other slots are fixed
	always_comb begin
		unique case (eff_addr[15:14])
			mmc_pkg::WIN_SLOT: page = page_index;
			mmc_pkg::LOW_SLOT: page = mmc_pkg::PAGE_LOW;
			mmc_pkg::MID_SLOT: page = mmc_pkg::PAGE_MID;
			default: page = mmc_pkg::PAGE_TOP;
		endcase
	end

	// Low local space keeps registers, RAM and data flash at their own place
	always_comb begin
		if (eff_addr < mmc_pkg::DFL_HI[15:0] + 16'h0001 && eff_addr[15:14] != mmc_pkg::WIN_SLOT
			&& ({2'b00, eff_addr} <= mmc_pkg::REG_TOP
			|| {2'b00, eff_addr} >= mmc_pkg::DFL_LO
			|| ({2'b00, eff_addr} >= mmc_pkg::RAM_END - RAM_SIZE
			&& {2'b00, eff_addr} < mmc_pkg::RAM_END))) begin
			global_addr = {2'b00, eff_addr};
		end else begin
			global_addr = {page, eff_addr[13:0]};
		end
		ga_ext = {1'b0, global_addr};
	end

	// Range checks; anything outside every resource is unimplemented
	always_comb begin
		is_pflash = ga_ext >= mmc_pkg::PFL_END - FLASH_SIZE;
		is_unimpl = !(is_pflash
			|| global_addr <= mmc_pkg::REG_TOP
			|| (global_addr < mmc_pkg::RAM_END && global_addr >= mmc_pkg::RAM_END - RAM_SIZE)
			|| (global_addr >= mmc_pkg::DFL_LO && global_addr <= mmc_pkg::DFL_HI));
	end
endmodule : page_map

/* hw/memory_map_mode_control.sv */
// Memory map control: mode, direct page, window page, arbitration, checks.
// Assumes hresetn is the device reset pin and the masters share hclk.
//
// How it works
// - Mode pin sampled when reset releases
// - Pin rules in reset, register bit after
// - Mode write only on allowed transition
// - Bad transition keeps bit, locks outside special
// - Secured device ignores all mode writes
// - Direct page: any time special, once normal
// - Direct base forms address bits 15 to 8
// - 256-byte direct page in both maps
// - Unimplemented processor access outside debug firmware raises system reset
// - Paging reaches 256 kB global space
// - Arbitrate two masters, separate map each
// - Special mode enters background debug after reset
// - Secured denies external program flash access
// - Four index bits pick window page
// - Window index resets to page 0x0E
`timescale 1ns/100ps
module memory_map_mode_control #(
	parameter logic [17:0] RAM_SIZE = 18'h01800, // Implemented RAM bytes
	parameter logic [18:0] FLASH_SIZE = 19'h10000 // Implemented flash bytes
) (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Reset pin, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // Read data
	output logic hresp, // Response, always OKAY
	input wire logic mode_select_pin_bit, // Mode pin, asynchronous
	input wire logic secured, // Device secured, asynchronous
	input wire logic cpu_req, // Processor access request
	input wire logic [15:0] cpu_addr, // Processor local address
	input wire logic cpu_direct, // Processor uses direct addressing
	input wire logic cpu_firmware, // Processor runs debug firmware
	input wire logic bdm_req, // Debug access request
	input wire logic [15:0] bdm_addr, // Debug local address
	input wire logic [3:0] bdm_page, // Debug program page index
	input wire logic debug_exit, // Debug leaves active state, pulse
	output logic cpu_grant, // Processor owns the bus this cycle
	output logic bdm_grant, // Debug module owns the bus this cycle
	output logic [17:0] global_addr, // Granted global address
	output logic global_valid, // Global address is valid
	output logic access_denied, // Debug flash access refused, pulse
	output logic illegal_reset, // System reset request, pulse
	output logic background_debug, // Active background debug state
	output logic normal_single_chip // Current mode is normal
);
	logic mode_meta_reg, mode_sync_reg; // Mode pin synchroniser
	logic sec_meta_reg, sec_sync_reg; // Secure input synchroniser
	logic captured_reg; // Pin value has been taken
	logic mode_reg, mode_next; // Mode bit
	logic lock_reg, lock_next; // Mode bit locked against writes
	logic [7:0] direct_reg, direct_next; // Direct page base
	logic direct_done_reg; // Direct page written once in normal
	logic [3:0] program_page_window_index_reg, program_page_window_index_next; // Program window page
	logic wr_pend_reg; // Write data phase pending
	logic [7:0] wr_idx_reg; // Index of pending write
	logic wr_mode, wr_direct, wr_program_page_window_index; // Per register write strobes
	logic cur_mode; // Effective mode
	logic addr_phase; // Address phase taken this edge
	logic [7:0] rd_value; // Read mux output
	logic [15:0] sel_addr; // Granted local address
	logic [17:0] map_addr; // Expanded address
	logic map_pflash, map_unimpl; // Range flags
	mmc_pkg::owner_t owner_reg, owner_next; // Last owner

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers: first stage feeds only the second
	// No reset on these flops: the pin value must reach the capture flop
	// while reset is still held, or every release would read special mode
	always_ff @(posedge hclk) begin
		mode_meta_reg <= mode_select_pin_bit;
		mode_sync_reg <= mode_meta_reg;
	end

	// Secure level keeps its value through reset, so no unsecured window
	// opens for the first cycles after release
	always_ff @(posedge hclk) begin
		sec_meta_reg <= secured;
		sec_sync_reg <= sec_meta_reg;
	end

	// Pin follows while reset holds; the register bit rules afterwards
	always_comb begin
		cur_mode = captured_reg ? mode_reg : mode_sync_reg;
		normal_single_chip = cur_mode;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, word transfers only
	always_comb begin
		addr_phase = hsel && hready && htrans == mmc_pkg::HTRANS_NONSEQ;
		hreadyout = 1'b1;
		hresp = mmc_pkg::HRESP_OKAY;
	end

	// Remember a write until its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
		end else begin
			// Range check taken in the address phase; haddr moves on after it
			wr_pend_reg <= addr_phase && hwrite && haddr[31:10] == 22'h0;
			wr_idx_reg <= haddr[9:2];
		end
	end

	// Reserved and unmapped indices match no strobe, so writes vanish
	always_comb begin
		wr_mode = wr_pend_reg && wr_idx_reg == mmc_pkg::IDX_MODE;
		wr_direct = wr_pend_reg && wr_idx_reg == mmc_pkg::IDX_DIRECT;
		wr_program_page_window_index = wr_pend_reg && wr_idx_reg == mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX;
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode write filter; lock and security both block it
	always_comb begin
		mode_next = mode_reg;
		lock_next = lock_reg;
		if (wr_mode && !sec_sync_reg && !lock_reg) begin
			if (mode_reg == mmc_pkg::MODE_SPECIAL) begin
				mode_next = hwdata[mmc_pkg::MODE_BIT];
			end else if (hwdata[mmc_pkg::MODE_BIT] == mmc_pkg::MODE_SPECIAL) begin
				lock_next = 1'b1;
			end
		end
	end

	// Mode capture on release and its write path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			captured_reg <= 1'b0;
			mode_reg <= mmc_pkg::MODE_NORMAL;
			lock_reg <= 1'b0;
		end else if (!captured_reg) begin
			captured_reg <= 1'b1;
			mode_reg <= mode_sync_reg;
		end else begin
			mode_reg <= mode_next;
			lock_reg <= lock_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Direct page: open in special, write-once in normal
	always_comb begin
		direct_next = direct_reg;
		if (wr_direct && (cur_mode == mmc_pkg::MODE_SPECIAL || !direct_done_reg)) begin
			direct_next = hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			direct_reg <= mmc_pkg::DIRECT_RST;
			direct_done_reg <= 1'b0;
		end else begin
			direct_reg <= direct_next;
			if (wr_direct && cur_mode == mmc_pkg::MODE_NORMAL) begin
				direct_done_reg <= 1'b1;
			end
		end
	end

	// Window page index, written any time
	always_comb begin
		program_page_window_index_next = wr_program_page_window_index ? hwdata[3:0] : program_page_window_index_reg;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			program_page_window_index_reg <= mmc_pkg::PROGRAM_PAGE_WINDOW_INDEX_RST;
		end else begin
			program_page_window_index_reg <= program_page_window_index_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux looks at next values so a read right after a write is fresh
	always_comb begin
		unique case (haddr[9:2])
			mmc_pkg::IDX_MODE: rd_value = {(captured_reg ? mode_next : mode_sync_reg), 7'h00};
			mmc_pkg::IDX_DIRECT: rd_value = direct_next;
			mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX: rd_value = {4'h0, program_page_window_index_next};
			default: rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= (haddr[31:10] == 22'h0) ? {24'h000000, rd_value} : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration: debug module first, it stalls the processor for every cycle it requests
	always_comb begin
		bdm_grant = bdm_req;
		cpu_grant = cpu_req && !bdm_req;
		owner_next = bdm_req ? mmc_pkg::OWN_BDM : (cpu_req ? mmc_pkg::OWN_CPU : mmc_pkg::OWN_NONE);
		sel_addr = bdm_req ? bdm_addr : cpu_addr;
	end

	// One mapper; each master brings its own page and direct rules
	page_map #(
		.RAM_SIZE(RAM_SIZE),
		.FLASH_SIZE(FLASH_SIZE)
	) u_map (
		.local_addr(sel_addr),
		.direct_mode(cpu_grant && cpu_direct),
		.direct_base(direct_reg),
		.page_index(bdm_req ? bdm_page : program_page_window_index_reg),
		.global_addr(map_addr),
		.is_pflash(map_pflash),
		.is_unimpl(map_unimpl)
	);

	// Registered global access and the checks on it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			owner_reg <= mmc_pkg::OWN_NONE;
			global_addr <= 18'h00000;
			global_valid <= 1'b0;
			access_denied <= 1'b0;
			illegal_reset <= 1'b0;
		end else begin
			owner_reg <= owner_next;
			global_addr <= map_addr;
			access_denied <= bdm_grant && sec_sync_reg && map_pflash;
			global_valid <= (cpu_grant || bdm_grant) && !(bdm_grant && sec_sync_reg && map_pflash);
			illegal_reset <= cpu_grant && map_unimpl && !cpu_firmware;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Background debug entered after reset in special mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			background_debug <= 1'b0;
		end else if (!captured_reg) begin
			background_debug <= mode_sync_reg == mmc_pkg::MODE_SPECIAL;
		end else if (debug_exit) begin
			background_debug <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// All checks sleep while reset is held; the capture cycle is checked first
	chk_mode_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		!captured_reg |=> mode_reg == $past(mode_sync_reg))
		else $error("mode not captured from pin");
	chk_mode_source: assert property (@(posedge hclk) disable iff (!hresetn)
		!captured_reg |-> normal_single_chip == mode_sync_reg)
		else $error("mode does not follow pin before capture");
	chk_secure_block: assert property (@(posedge hclk) disable iff (!hresetn)
		captured_reg && sec_sync_reg |=> $stable(mode_reg) && $stable(lock_reg))
		else $error("mode changed while secured");
	chk_no_return: assert property (@(posedge hclk) disable iff (!hresetn)
		captured_reg && mode_reg == mmc_pkg::MODE_NORMAL |=> mode_reg == mmc_pkg::MODE_NORMAL)
		else $error("normal mode left");
	chk_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
		captured_reg && wr_mode && !sec_sync_reg && mode_reg == mmc_pkg::MODE_NORMAL
		&& hwdata[mmc_pkg::MODE_BIT] == mmc_pkg::MODE_SPECIAL |=> lock_reg)
		else $error("refused transition did not lock");
	chk_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		lock_reg |=> lock_reg && $stable(mode_reg))
		else $error("locked mode bit changed");
	chk_direct_once: assert property (@(posedge hclk) disable iff (!hresetn)
		direct_done_reg && normal_single_chip |=> $stable(direct_reg))
		else $error("direct page rewritten in normal mode");
	chk_program_page_window_index_write: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_program_page_window_index |=> program_page_window_index_reg == $past(hwdata[3:0]))
		else $error("window page not written");
	chk_grant_excl: assert property (@(posedge hclk) disable iff (!hresetn)
		!(cpu_grant && bdm_grant) && (!bdm_req || bdm_grant))
		else $error("arbitration broken");
	chk_flash_deny: assert property (@(posedge hclk) disable iff (!hresetn)
		access_denied |-> !global_valid)
		else $error("denied access still issued");
	chk_illegal_rst: assert property (@(posedge hclk) disable iff (!hresetn)
		illegal_reset |-> $past(cpu_grant) && owner_reg == mmc_pkg::OWN_CPU)
		else $error("reset request without processor access");
	cov_mode_leave: cover property (@(posedge hclk) disable iff (!hresetn)
		captured_reg && $rose(mode_reg));
	cov_lock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lock_reg));
	cov_illegal: cover property (@(posedge hclk) disable iff (!hresetn) illegal_reset);
	cov_deny: cover property (@(posedge hclk) disable iff (!hresetn) access_denied);
endmodule : memory_map_mode_control

/* bench/master_model.sv */
// Behavioural model of the processor and debug bus masters.
// Assumes the bench calls its tasks from one process, clocked by hclk.
`timescale 1ns/100ps
module master_model (
	input wire logic hclk, // Bus clock
	output logic cpu_req, // Processor request
	output logic [15:0] cpu_addr, // Processor local address
	output logic cpu_direct, // Direct addressing
	output logic cpu_firmware, // Debug firmware running
	output logic bdm_req, // Debug request
	output logic [15:0] bdm_addr, // Debug local address
	output logic [3:0] bdm_page, // Debug window page
	output logic debug_exit // Leave debug state, pulse
);
	////////////////////////////////////////////////////////////////////////////
	// Idle values at time zero
	initial begin
		{cpu_req, cpu_direct, cpu_firmware, bdm_req, debug_exit} = 5'h00;
		cpu_addr = 16'h0000;
		bdm_addr = 16'h0000;
		bdm_page = 4'h0;
	end
	// One request cycle, launched just after an edge
	task drive(input logic cr, input logic [15:0] ca, input logic cd, input logic cf,
		input logic br, input logic [15:0] ba, input logic [3:0] bp);
		@(posedge hclk);
		cpu_req <= cr;
		cpu_addr <= ca;
		cpu_direct <= cd;
		cpu_firmware <= cf;
		bdm_req <= br;
		bdm_addr <= ba;
		bdm_page <= bp;
	endtask : drive
	// Release; addresses flip so a stale value never passes for a live one
	task idle;
		@(posedge hclk);
		cpu_req <= 1'b0;
		bdm_req <= 1'b0;
		cpu_addr <= ~cpu_addr;
		bdm_addr <= ~bdm_addr;
		bdm_page <= ~bdm_page;
	endtask : idle
	// Single cycle exit pulse
	task exit_pulse;
		@(posedge hclk);
		debug_exit <= 1'b1;
		@(posedge hclk);
		debug_exit <= 1'b0;
	endtask : exit_pulse
endmodule : master_model

/* bench/memory_map_mode_control_tb.sv */
// Self-checking bench for the memory map and mode control block.
// Assumes a single slave on AHB-Lite and the master model on the far side.
`timescale 1ns/100ps
module memory_map_mode_control_tb;
	logic hclk, hresetn, hsel, hwrite, pin, sec; // Clock, reset, bus, pins
	logic [31:0] haddr, hwdata, hrdata, rd; // Bus data
	logic [1:0] htrans; // Transfer type
	logic hreadyout, hresp; // Slave answer
	logic cpu_req, cpu_direct, cpu_firmware, bdm_req, debug_exit; // Master lines
	logic [15:0] cpu_addr, bdm_addr; // Local addresses
	logic [3:0] bdm_page; // Debug page
	logic cpu_grant, bdm_grant, global_valid, access_denied; // Map outputs
	logic illegal_reset, background_debug, normal_single_chip; // Status
	logic [17:0] global_addr; // Expanded address
	int n_errors, samples_checked; // Counters
	////////////////////////////////////////////////////////////////////////////
	memory_map_mode_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .mode_select_pin_bit(pin), .secured(sec), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_direct(cpu_direct), .cpu_firmware(cpu_firmware),
		.bdm_req(bdm_req), .bdm_addr(bdm_addr), .bdm_page(bdm_page),
		.debug_exit(debug_exit), .cpu_grant(cpu_grant), .bdm_grant(bdm_grant),
		.global_addr(global_addr), .global_valid(global_valid),
		.access_denied(access_denied), .illegal_reset(illegal_reset),
		.background_debug(background_debug), .normal_single_chip(normal_single_chip));
	master_model mm (.hclk(hclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
		.cpu_direct(cpu_direct), .cpu_firmware(cpu_firmware), .bdm_req(bdm_req),
		.bdm_addr(bdm_addr), .bdm_page(bdm_page), .debug_exit(debug_exit));
	////////////////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// Verdict and end of run
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	// One comparison
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	// Bounded wait for hready high at a rising edge
	task wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_errors++;
			$display("MISMATCH %0t bus hang", $time);
			end_of_test();
		end
	endtask : wait_ready
	// Single word transfer; byte address is four times the index
	task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= mmc_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {22'h000000, idx, 2'b00};
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check({31'h0, hresp}, {31'h0, mmc_pkg::HRESP_OKAY}, "hresp");
	endtask : bus
	// Read one register and compare
	task rchk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h00000000);
		check(rd, exp, "register read");
	endtask : rchk
	// Reset with given mode pin and security level, held 4 cycles
	task do_reset(input logic p, input logic s);
		@(posedge hclk);
		hresetn <= 1'b0;
		pin <= p;
		sec <= s;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask : do_reset
	// One master cycle, checking grants, then waiting for the registered results
	task acc(input logic cr, input logic [15:0] ca, input logic cd, input logic cf,
		input logic br, input logic [15:0] ba, input logic [3:0] bp);
		mm.drive(cr, ca, cd, cf, br, ba, bp);
		#1;
		check({30'h0, cpu_grant, bdm_grant}, {30'h0, cr & ~br, br}, "grants");
		mm.idle();
		#1;
	endtask : acc
	////////////////////////////////////////////////////////////////////////////
	// Special mode out of reset, reset values, reserved places
	task t_special_reset;
		do_reset(1'b0, 1'b0);
		rchk(mmc_pkg::IDX_MODE, 32'h00000000);
		check({31'h0, background_debug}, 32'h1, "debug after reset");
		rchk(mmc_pkg::IDX_DIRECT, 32'h00000000);
		rchk(mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX, 32'h0000000E);
		bus(1'b1, mmc_pkg::IDX_RSVD_A, 32'hFFFFFFFF);
		rchk(mmc_pkg::IDX_RSVD_A, 32'h00000000);
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		rchk(8'h30, 32'h00000000);
		mm.exit_pulse();
		@(posedge hclk);
		#1;
		check({31'h0, background_debug}, 32'h0, "debug exit");
	endtask : t_special_reset
	// Direct page rewritable in special mode
	task t_special_direct;
		bus(1'b1, mmc_pkg::IDX_DIRECT, 32'h00000012);
		bus(1'b1, mmc_pkg::IDX_DIRECT, 32'h00000080);
		rchk(mmc_pkg::IDX_DIRECT, 32'h00000080);
	endtask : t_special_direct
	// Window paging, direct addressing, arbitration, unimplemented access
	task t_map;
		bus(1'b1, mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX, 32'h000000FF);
		rchk(mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX, 32'h0000000F);
		bus(1'b1, mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX, 32'h00000005);
		acc(1'b1, 16'h8123, 1'b0, 1'b0, 1'b0, 16'h0000, 4'h0);
		check({14'h0, global_addr}, 32'h00014123, "window");
		check({31'h0, global_valid}, 32'h1, "valid");
		acc(1'b1, 16'h0023, 1'b1, 1'b0, 1'b0, 16'h0000, 4'h0);
		check({14'h0, global_addr}, 32'h00014023, "direct");
		acc(1'b1, 16'h8123, 1'b0, 1'b0, 1'b1, 16'h8001, 4'h3);
		check({14'h0, global_addr}, 32'h0000C001, "debug map");
		bus(1'b1, mmc_pkg::IDX_PROGRAM_PAGE_WINDOW_INDEX, 32'h00000001);
		acc(1'b1, 16'h8123, 1'b0, 1'b0, 1'b0, 16'h0000, 4'h0);
		check({31'h0, illegal_reset}, 32'h1, "unimplemented");
		acc(1'b1, 16'h8123, 1'b0, 1'b1, 1'b0, 16'h0000, 4'h0);
		check({31'h0, illegal_reset}, 32'h0, "firmware");
	endtask : t_map
	// Allowed and refused mode changes
	task t_mode_change;
		bus(1'b1, mmc_pkg::IDX_MODE, 32'h00000000);
		rchk(mmc_pkg::IDX_MODE, 32'h00000000);
		bus(1'b1, mmc_pkg::IDX_MODE, 32'h00000080);
		rchk(mmc_pkg::IDX_MODE, 32'h00000080);
		check({31'h0, normal_single_chip}, 32'h1, "normal now");
		bus(1'b1, mmc_pkg::IDX_MODE, 32'h00000000);
		rchk(mmc_pkg::IDX_MODE, 32'h00000080);
	endtask : t_mode_change
	// Normal mode out of reset, direct page write-once
	task t_normal;
		do_reset(1'b1, 1'b0);
		rchk(mmc_pkg::IDX_MODE, 32'h00000080);
		check({31'h0, background_debug}, 32'h0, "no debug");
		bus(1'b1, mmc_pkg::IDX_DIRECT, 32'h00000040);
		bus(1'b1, mmc_pkg::IDX_DIRECT, 32'h00000022);
		rchk(mmc_pkg::IDX_DIRECT, 32'h00000040);
	endtask : t_normal
	// Secured device: mode writes ignored, debug flash access refused
	task t_secured;
		do_reset(1'b0, 1'b1);
		bus(1'b1, mmc_pkg::IDX_MODE, 32'h00000080);
		rchk(mmc_pkg::IDX_MODE, 32'h00000000);
		acc(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h8000, 4'hE);
		check({30'h0, access_denied, global_valid}, 32'h2, "denied");
	endtask : t_secured
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		n_errors = 0;
		samples_checked = 0;
		{hresetn, hsel, hwrite, pin, sec} = 5'h00;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'b00;
		t_special_reset();
		t_special_direct();
		t_map();
		t_mode_change();
		t_normal();
		t_secured();
		end_of_test();
	end
endmodule : memory_map_mode_control_tb
